/* hw/temp_sense_power_regs.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - trim register at 0x12, 8 bits read/write, resets to 0x3A.
// - readout refreshed every interval register plus one frames.
// - readout at 0x14 is read-only 8 bits, rising with temperature.
// - each update samples sensor, digitises, latches result into readout.
// - at reset interval, readout updates every 256 frames.
// - power-down bit 1 switches the sensor off; clear keeps it running.
// - power-down bit 7 at 0x15 puts whole chip into deep sleep.
// - register port stays working, all registers accessible in deep sleep.
// - settings kept in sleep; prior state resumes when bit 7 clears.
// - bit 6 powers down ramp DAC and blanks image.
// - bit 5 powers down bias generator; host should keep it clear.
// - bit 4 powers down top ramp buffer and blanks image.
// - bit 3 powers down bottom ramp buffer and blanks image.
// - bit 2 bypasses and powers down cathode supply converter.
module temp_sense_power_regs
(
    input wire logic clock, // system clock, 100 MHz
    input wire logic rstn, // async reset, active low
    input wire logic clockEnable, // freezes all state when low
    input wire logic regWrite, // register write strobe from serial port
    input wire logic regRead, // register read strobe from serial port
    input wire logic [7:0] regAddr, // register offset
    input wire logic [7:0] regWdata, // write data
    output logic [7:0] regRdata, // read data, registered
    output logic regRvalid, // read data valid pulse
    input wire logic frameStart, // frame start pin, asynchronous
    input wire logic [7:0] adcCode, // digitiser result, same clock
    input wire logic adcDone, // digitiser finished pulse
    output logic sampleStart, // starts junction sample and conversion
    output logic [7:0] offsetTrim, // trim to sensor front end
    output logic sensorEnable, // sensor analogue power
    output logic rampDacEnable, // ramp DAC power
    output logic biasGenEnable, // bias generator power
    output logic topRampEnable, // top ramp buffer power
    output logic bottomRampEnable, // bottom ramp buffer power
    output logic cathodeConvEnable, // cathode converter power
    output logic cathodeBypass, // cathode converter bypass switch
    output logic imageBlank, // blank displayed image
    output logic deepSleep // chip-wide sleep, register port stays on
);
    import tsp_pkg::*;

    logic [7:0] offsetTrim_r;
    logic [7:0] updateInterval_r;
    logic [7:0] readout_r;
    logic [7:0] powerDown_r;
    logic [7:0] regRdata_nxt;
    logic frameLevel;
    logic frameLevelD_r;
    logic frameTick;
    logic running;
    logic updatePulse;
    logic sleepBit;
    logic sensorOff;
    tsp_conv_t conv_r;
    tsp_conv_t conv_nxt;

    // next values of the registered power outputs
    logic deepSleep_nxt;
    logic sensorEnable_nxt;
    logic rampDacEnable_nxt;
    logic biasGenEnable_nxt;
    logic topRampEnable_nxt;
    logic bottomRampEnable_nxt;
    logic cathodeConvEnable_nxt;
    logic cathodeBypass_nxt;
    logic imageBlank_nxt;

    // write decode; readout address has no write path
    logic wrTrim;
    logic wrInterval;
    logic wrPower;
    assign wrTrim = regWrite && (regAddr == OFS_OFFSET_TRIM);
    assign wrInterval = regWrite && (regAddr == OFS_UPDATE_INTERVAL);
    assign wrPower = regWrite && (regAddr == OFS_POWER_DOWN);

    // power field decode
    assign sleepBit = powerDown_r[BIT_GLOBAL_SLEEP];
    assign sensorOff = powerDown_r[BIT_SENSOR_OFF];
    assign running = !sleepBit && !sensorOff;

    // read address decode, one select per mapped register
    logic selTrim;
    logic selInterval;
    logic selReadout;
    logic selPower;
    assign selTrim = (regAddr == OFS_OFFSET_TRIM);
    assign selInterval = (regAddr == OFS_UPDATE_INTERVAL);
    assign selReadout = (regAddr == OFS_READOUT);
    assign selPower = (regAddr == OFS_POWER_DOWN);

    // read mux; unmapped offsets read zero so a probe sees nothing stale
    assign regRdata_nxt =
        selTrim ? offsetTrim_r :
        selInterval ? updateInterval_r :
        selReadout ? readout_r :
        selPower ? powerDown_r : 8'h00;

    // frame pin crosses into the clock domain before edge detection
    tsp_sync2 tsp_sync2_inst (
        .clock(clock),
        .rstn(rstn),
        .clockEnable(clockEnable),
        .asyncIn(frameStart),
        .syncOut(frameLevel)
    );
    assign frameTick = frameLevel && !frameLevelD_r;

    tsp_frame_pacer tsp_frame_pacer_inst (
        .clock(clock),
        .rstn(rstn),
        .clockEnable(clockEnable),
        .running(running),
        .frameTick(frameTick),
        .interval(updateInterval_r),
        .updatePulse(updatePulse)
    );

    // conversion sequencer: sample, wait for digitiser, latch
    always_comb begin
        conv_nxt = conv_r;
        unique case (conv_r)
            TSP_IDLE: begin
                if (updatePulse) begin
                    conv_nxt = TSP_SAMPLE;
                end
            end
            TSP_SAMPLE: begin
                conv_nxt = TSP_WAIT;
            end
            TSP_WAIT: begin
                if (adcDone || !running) begin
                    conv_nxt = TSP_IDLE;
                end
            end
        endcase
    end
    assign sampleStart = (conv_r == TSP_SAMPLE);

    // trim register; the register port works regardless of sleep
    // the host reloads it from its calibration store after power-up
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            offsetTrim_r <= RST_OFFSET_TRIM;
        end else if (clockEnable && wrTrim) begin
            offsetTrim_r <= regWdata;
        end
    end

    // interval register; values below 0x02 are kept as written,
    // only the host is barred from using them
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            updateInterval_r <= RST_UPDATE_INTERVAL;
        end else if (clockEnable && wrInterval) begin
            updateInterval_r <= regWdata;
        end
    end

    // power-down register; bit 0 is unused and always reads zero
    // sleep never clears it, so every setting survives deep sleep
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            powerDown_r <= RST_POWER_DOWN;
        end else if (clockEnable && wrPower) begin
            powerDown_r <= regWdata & POWER_DOWN_MASK;
        end
    end

    // readout latched only from the digitiser, host writes never reach it
    // a conversion cut short by power-down leaves the old reading
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            readout_r <= RST_READOUT;
        end else if (clockEnable && conv_r == TSP_WAIT && adcDone && running) begin
            readout_r <= adcCode;
        end
    end

    // conversion sequencer state
    // one sample per update pulse, never two in flight
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv_r <= TSP_IDLE;
        end else if (clockEnable) begin
            conv_r <= conv_nxt;
        end
    end

    // edge history of the synchronised frame level; resets to the pin's
    // idle low so the release of reset makes no false frame
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            frameLevelD_r <= 1'b0;
        end else if (clockEnable) begin
            frameLevelD_r <= frameLevel;
        end
    end

    // read valid pulse, one cycle after the read strobe
    // back-to-back reads give back-to-back pulses
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRvalid <= 1'b0;
        end else if (clockEnable) begin
            regRvalid <= regRead;
        end
    end

    // read data holds until the next read
    // so a slow serial front end may take it late
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdata <= STAT_IDLE;
        end else if (clockEnable && regRead) begin
            regRdata <= regRdata_nxt;
        end
    end

    // next values of the power outputs; deep sleep overrides each stored bit except the cathode bypass
    // but leaves the register alone, so waking restores the old state
    assign deepSleep_nxt = sleepBit;
    assign sensorEnable_nxt = running;
    assign rampDacEnable_nxt = !sleepBit && !powerDown_r[BIT_RAMP_DAC_OFF];
    assign biasGenEnable_nxt = !sleepBit && !powerDown_r[BIT_BIAS_GEN_OFF];
    assign topRampEnable_nxt = !sleepBit && !powerDown_r[BIT_TOP_RAMP_OFF];
    assign bottomRampEnable_nxt = !sleepBit && !powerDown_r[BIT_BOTTOM_RAMP_OFF];
    assign cathodeConvEnable_nxt = !sleepBit && !powerDown_r[BIT_CATHODE_BYPASS];
    assign cathodeBypass_nxt = powerDown_r[BIT_CATHODE_BYPASS];
    // any ramp path off leaves nothing to show; bias off only dims
    assign imageBlank_nxt = sleepBit || powerDown_r[BIT_RAMP_DAC_OFF] ||
        powerDown_r[BIT_TOP_RAMP_OFF] ||
        powerDown_r[BIT_BOTTOM_RAMP_OFF];

    // trim copy to the sensor front end
    // registered so the analogue side never sees a decode glitch
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            offsetTrim <= RST_OFFSET_TRIM;
        end else if (clockEnable) begin
            offsetTrim <= offsetTrim_r;
        end
    end

    // chip-wide sleep level
    // the register port runs on through it; analogue blocks, the frame pacer and the conversion sequencer rest
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            deepSleep <= 1'b0;
        end else if (clockEnable) begin
            deepSleep <= deepSleep_nxt;
        end
    end

    // sensor supply; off with its own bit or in sleep
    // the pacer stops at the same moment, but an update pulse registered with the write still starts one sample, never latched
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sensorEnable <= 1'b0;
        end else if (clockEnable) begin
            sensorEnable <= sensorEnable_nxt;
        end
    end

    // ramp DAC supply
    // off blanks the image; an external ramp may stand in
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rampDacEnable <= 1'b0;
        end else if (clockEnable) begin
            rampDacEnable <= rampDacEnable_nxt;
        end
    end

    // bias generator supply
    // off dims rather than blanks, so imageBlank ignores it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            biasGenEnable <= 1'b0;
        end else if (clockEnable) begin
            biasGenEnable <= biasGenEnable_nxt;
        end
    end

    // top ramp buffer supply
    // either buffer off leaves the image blank
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            topRampEnable <= 1'b0;
        end else if (clockEnable) begin
            topRampEnable <= topRampEnable_nxt;
        end
    end

    // bottom ramp buffer supply
    // mirrors the top buffer path
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bottomRampEnable <= 1'b0;
        end else if (clockEnable) begin
            bottomRampEnable <= bottomRampEnable_nxt;
        end
    end

    // cathode converter supply
    // dropped in sleep and when bypassed for an external supply
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cathodeConvEnable <= 1'b0;
        end else if (clockEnable) begin
            cathodeConvEnable <= cathodeConvEnable_nxt;
        end
    end

    // cathode converter bypass switch
    // follows the stored bit in sleep too; the converter is off anyway
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cathodeBypass <= 1'b0;
        end else if (clockEnable) begin
            cathodeBypass <= cathodeBypass_nxt;
        end
    end

    // blank request to the display path
    // resets high so nothing shows before the enables have settled
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            imageBlank <= 1'b1;
        end else if (clockEnable) begin
            imageBlank <= imageBlank_nxt;
        end
    end
endmodule

/* hw/tsp_pkg.sv */
package tsp_pkg;
    // register offsets on the serial register port
    localparam logic [7:0] OFS_OFFSET_TRIM = 8'h12;
    localparam logic [7:0] OFS_UPDATE_INTERVAL = 8'h13;
    localparam logic [7:0] OFS_READOUT = 8'h14;
    localparam logic [7:0] OFS_POWER_DOWN = 8'h15;
    // reset values
    localparam logic [7:0] RST_OFFSET_TRIM = 8'h3A;
    localparam logic [7:0] RST_UPDATE_INTERVAL = 8'hFF;
    localparam logic [7:0] RST_READOUT = 8'h00;
    localparam logic [7:0] RST_POWER_DOWN = 8'h00;
    // power-down field positions
    localparam int BIT_GLOBAL_SLEEP = 7;
    localparam int BIT_RAMP_DAC_OFF = 6;
    localparam int BIT_BIAS_GEN_OFF = 5;
    localparam int BIT_TOP_RAMP_OFF = 4;
    localparam int BIT_BOTTOM_RAMP_OFF = 3;
    localparam int BIT_CATHODE_BYPASS = 2;
    localparam int BIT_SENSOR_OFF = 1;
    // writable bits of the power-down register; bit 0 reads zero
    localparam logic [7:0] POWER_DOWN_MASK = 8'hFE;
    // read data reset value and sensor conversion states
    localparam logic [7:0] STAT_IDLE = 8'h00;
    typedef enum logic [1:0] {TSP_IDLE, TSP_SAMPLE, TSP_WAIT} tsp_conv_t;
endpackage

/* hw/tsp_sync2.sv */
`timescale 1ns/1ns
// two-stage synchroniser for levels arriving from pins
module tsp_sync2 (
    input wire logic clock, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic clockEnable, // freezes state when low
    input wire logic asyncIn, // level from outside the domain
    output logic syncOut // level safe to read
);
    logic stage1_r;
    // first stage feeds only the second
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stage1_r <= 1'b0;
            syncOut <= 1'b0;
        end else if (clockEnable) begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule

/* hw/tsp_frame_pacer.sv */
`timescale 1ns/1ns
// counts frame starts and fires an update every interval+1 frames
module tsp_frame_pacer
    import tsp_pkg::*;
(
    input wire logic clock, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic clockEnable, // freezes state when low
    input wire logic running, // sensor powered and chip awake
    input wire logic frameTick, // one-cycle pulse per frame
    input wire logic [7:0] interval, // update interval register
    output logic updatePulse // one-cycle update request
);
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic wrap;
    // interval n gives n+1 frames; >= also recovers if n shrinks mid-count
    assign wrap = frameTick && (count_r >= interval);
    // stopped counter restarts from zero on power return
    assign count_nxt = !running ? 8'h00 : wrap ? 8'h00 :
        frameTick ? count_r + 8'h01 : count_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_r <= 8'h00;
            updatePulse <= 1'b0;
        end else if (clockEnable) begin
            count_r <= count_nxt;
            updatePulse <= running && wrap;
        end
    end
endmodule

/* verification/tsp_adc_model.sv */
`timescale 1ns/1ns
// digitiser stand-in: answers each conversion start after a chosen delay
module tsp_adc_model (
    input wire logic clock, // system clock
    input wire logic sampleStart, // conversion request
    input wire logic [7:0] tempCode, // code the junction would give
    input wire logic [3:0] latency, // cycles to finish, at least 1
    output logic adcDone, // finished pulse
    output logic [7:0] adcCode // result, garbage outside the pulse
);
    // idle data after each answer shows the inverse so a stale latch cannot pass; before the first it reads 0x00
    initial begin
        adcDone = 1'b0;
        adcCode = 8'h00;
        forever begin
            @(posedge clock);
            if (sampleStart === 1'b1) begin
                repeat (latency) @(posedge clock);
                #1 adcDone = 1'b1;
                adcCode = tempCode;
                @(posedge clock);
                #1 adcDone = 1'b0;
                adcCode = ~tempCode;
            end
        end
    end
endmodule

/* verification/tsp_assertions.sv */
`timescale 1ns/1ns
// port-level checks on the register port and power outputs
module tsp_assertions
    import tsp_pkg::*;
(
    input wire logic clock, // clock
    input wire logic rstn, // reset, active low
    input wire logic clockEnable, // run enable
    input wire logic regWrite, // write strobe
    input wire logic regRead, // read strobe
    input wire logic [7:0] regAddr, // offset
    input wire logic [7:0] regWdata, // write data
    input wire logic regRvalid, // read valid
    input wire logic sampleStart, // conversion start
    input wire logic [7:0] offsetTrim, // trim copy
    input wire logic sensorEnable, // sensor power
    input wire logic rampDacEnable, // ramp DAC power
    input wire logic biasGenEnable, // bias power
    input wire logic cathodeConvEnable, // converter power
    input wire logic imageBlank, // blank
    input wire logic deepSleep // sleep
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // power-down register write taken at this edge
    wire logic pdWr = clockEnable && regWrite && regAddr == OFS_POWER_DOWN;
    read_answer_a: assert property (
        clockEnable && regRead |=> regRvalid) else $error("read not answered");
    valid_pulse_a: assert property (
        clockEnable && !regRead |=> !regRvalid) else $error("stray read valid");
    // outputs are registered from the register, so they move one edge later
    trim_copy_a: assert property (
        clockEnable && regWrite && regAddr == OFS_OFFSET_TRIM |=> ##1
        offsetTrim == $past(regWdata, 2)) else $error("trim output wrong");
    sleep_follow_a: assert property (
        pdWr |=> ##1 deepSleep == $past(regWdata[7], 2)) else $error("sleep level wrong");
    sensor_power_a: assert property (
        pdWr |=> ##1 sensorEnable != ($past(regWdata[1], 2) | $past(regWdata[7], 2)))
        else $error("sensor power wrong");
    ramp_power_a: assert property (
        pdWr |=> ##1 rampDacEnable != ($past(regWdata[6], 2) | $past(regWdata[7], 2)))
        else $error("ramp power wrong");
    bias_power_a: assert property (
        pdWr |=> ##1 biasGenEnable != ($past(regWdata[5], 2) | $past(regWdata[7], 2)))
        else $error("bias power wrong");
    conv_power_a: assert property (
        pdWr |=> ##1 cathodeConvEnable != ($past(regWdata[2], 2) | $past(regWdata[7], 2)))
        else $error("converter power wrong");
    blank_follow_a: assert property (
        pdWr |=> ##1 imageBlank == (|($past(regWdata, 2) & 8'hD8))) else $error("blank wrong");
    sample_gate_a: assert property (
        sampleStart |-> sensorEnable && !deepSleep) else $error("sample while off");
    sample_pulse_a: assert property (
        sampleStart |=> !sampleStart) else $error("start not a pulse");
    cover property (pdWr && regWdata[7]);
    cover property (sampleStart);
    cover property (clockEnable && regWrite && regAddr == OFS_READOUT);
endmodule

/* verification/temp_sense_power_regs_test.sv */
`timescale 1ns/1ns
// drives register port and frame pin; digitiser model answers conversions
module temp_sense_power_regs_test;
    import tsp_pkg::*;
    logic clock = 0, rstn = 0, clockEnable = 1, regWrite = 0, regRead = 0, frameStart = 0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, tempCode = 8'h00;
    logic [7:0] regRdata, offsetTrim, adcCode;
    logic [3:0] latency = 4'h3;
    logic regRvalid, adcDone, sampleStart, sensorEnable, rampDacEnable, biasGenEnable;
    logic topRampEnable, bottomRampEnable, cathodeConvEnable, cathodeBypass, imageBlank, deepSleep;
    int miscompares = 0, samples_checked = 0;
    // calibration store contents and the gain divider offset, which lies outside this block
    localparam logic [7:0] NV_TRIM = 8'h40;
    localparam logic [7:0] NV_GAIN = 8'h20;
    localparam logic [7:0] OFS_GAIN_DIVIDER = 8'h11;
    wire logic [7:0] pwrView = {1'b0, rampDacEnable, biasGenEnable, topRampEnable,
        bottomRampEnable, cathodeConvEnable, cathodeBypass, imageBlank};
    temp_sense_power_regs temp_sense_power_regs_inst (.clock(clock), .rstn(rstn),
        .clockEnable(clockEnable), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
        .frameStart(frameStart), .adcCode(adcCode), .adcDone(adcDone),
        .sampleStart(sampleStart), .offsetTrim(offsetTrim), .sensorEnable(sensorEnable),
        .rampDacEnable(rampDacEnable), .biasGenEnable(biasGenEnable),
        .topRampEnable(topRampEnable), .bottomRampEnable(bottomRampEnable),
        .cathodeConvEnable(cathodeConvEnable), .cathodeBypass(cathodeBypass),
        .imageBlank(imageBlank), .deepSleep(deepSleep));
    tsp_adc_model tsp_adc_model_inst (.clock(clock), .sampleStart(sampleStart),
        .tempCode(tempCode), .latency(latency), .adcDone(adcDone), .adcCode(adcCode));
    initial forever #5 clock = ~clock;
    task check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // extra edge at the end lets registered power outputs settle
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge clock);
        #1 regWrite = 1'b0;
        regAddr = ~a;
        regWdata = ~d;
        @(posedge clock);
        #1;
    endtask
    task rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        #1 regRead = 1'b1;
        regAddr = a;
        @(posedge clock);
        #1 check({7'h00, regRvalid}, 8'h01);
        check(regRdata, e);
        regRead = 1'b0;
        regAddr = ~a;
    endtask
    task wrchk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        wr(a, d);
        rdchk(a, e);
    endtask
    // the pin is asynchronous, so each level is held long past the synchroniser
    task frames(input int n);
        repeat (n) begin
            @(posedge clock);
            #1 frameStart = 1'b1;
            repeat (8) @(posedge clock);
            #1 frameStart = 1'b0;
            repeat (8) @(posedge clock);
        end
    endtask
    task t_reset;
        rdchk(OFS_OFFSET_TRIM, 8'h3A);
        rdchk(OFS_UPDATE_INTERVAL, 8'hFF);
        rdchk(OFS_READOUT, 8'h00);
        rdchk(OFS_POWER_DOWN, 8'h00);
        rdchk(8'h20, 8'h00);
        wrchk(OFS_OFFSET_TRIM, NV_TRIM, NV_TRIM);
        wrchk(OFS_GAIN_DIVIDER, NV_GAIN, 8'h00);
        $display("reset values done");
    endtask
    task t_regs;
        wrchk(OFS_OFFSET_TRIM, 8'hAD, 8'hAD);
        check(offsetTrim, 8'hAD);
        wrchk(OFS_READOUT, 8'h55, 8'h00);
        // frame pin stays low all through sleep
        wrchk(OFS_POWER_DOWN, 8'hFF, 8'hFE);
        check({6'h00, deepSleep, sensorEnable}, 8'h02);
        check(pwrView, 8'h03);
        wrchk(OFS_UPDATE_INTERVAL, 8'h02, 8'h02);
        wrchk(OFS_POWER_DOWN, 8'h00, 8'h00);
        rdchk(OFS_OFFSET_TRIM, 8'hAD);
        check({6'h00, deepSleep, sensorEnable}, 8'h01);
        // a write while the clock enable is low must not land
        clockEnable = 1'b0;
        wr(OFS_OFFSET_TRIM, 8'h5A);
        clockEnable = 1'b1;
        rdchk(OFS_OFFSET_TRIM, 8'hAD);
        $display("register access done");
    endtask
    task t_update;
        tempCode = 8'h47;
        frames(2);
        rdchk(OFS_READOUT, 8'h00);
        frames(1);
        rdchk(OFS_READOUT, 8'h47);
        // reading kept as room reference, trim set to reading plus 0x3D
        wrchk(OFS_OFFSET_TRIM, 8'h47 + 8'h3D, 8'h84);
        latency = 4'h9;
        tempCode = 8'h52;
        frames(3);
        rdchk(OFS_READOUT, 8'h52);
        frames(2);
        wr(OFS_POWER_DOWN, 8'h02);
        wr(OFS_POWER_DOWN, 8'h00);
        tempCode = 8'h61;
        frames(2);
        rdchk(OFS_READOUT, 8'h52);
        frames(1);
        rdchk(OFS_READOUT, 8'h61);
        $display("sensor pacing done");
    endtask
    task t_power;
        for (int b = 2; b < 7; b++) begin
            wr(OFS_POWER_DOWN, 8'h01 << b);
            check(pwrView, {1'b0, b != 6, b != 5, b != 4, b != 3, b != 2, b == 2,
                b == 6 || b == 4 || b == 3});
        end
        wr(OFS_POWER_DOWN, 8'h00);
        $display("power bits done");
    endtask
    task t_default;
        wrchk(OFS_UPDATE_INTERVAL, 8'hFF, 8'hFF);
        wr(OFS_POWER_DOWN, 8'h02);
        wr(OFS_POWER_DOWN, 8'h00);
        tempCode = 8'h33;
        frames(255);
        rdchk(OFS_READOUT, 8'h61);
        frames(1);
        rdchk(OFS_READOUT, 8'h33);
        $display("default interval done");
    endtask
    task results;
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        #1 rstn = 1'b1;
        t_reset();
        t_regs();
        t_update();
        t_power();
        t_default();
        results();
    end
    // run needs about 4650 cycles
    initial begin
        #90000;
        miscompares++;
        results();
    end
endmodule
bind temp_sense_power_regs tsp_assertions tsp_assertions_inst (.clock(clock), .rstn(rstn),
    .clockEnable(clockEnable), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRvalid(regRvalid), .sampleStart(sampleStart),
    .offsetTrim(offsetTrim), .sensorEnable(sensorEnable), .rampDacEnable(rampDacEnable),
    .biasGenEnable(biasGenEnable), .cathodeConvEnable(cathodeConvEnable),
    .imageBlank(imageBlank), .deepSleep(deepSleep));
